//--- shared/pew_consts.vh
/*
  constants for the parallel eeprom host controller: pin widths,
  page geometry and timing counts at a 50 MHz clock.
  assumes inclusion by bare name from the design file.
*/
`ifndef PEW_CONSTS_VH
`define PEW_CONSTS_VH

`define PEW_CLK_MHZ 50
`define PEW_ADDR_W 13
`define PEW_DATA_W 8
`define PEW_PAGE_LSB 6
`define PEW_PAGE_BYTES 64
// strobe widths and gaps in ns, then cycles (least time, rounded up)
`define PEW_STROBE_NS 100
`define PEW_STROBE_CYC ((`PEW_STROBE_NS * `PEW_CLK_MHZ + 999) / 1000)
`define PEW_READ_NS 200
`define PEW_READ_CYC ((`PEW_READ_NS * `PEW_CLK_MHZ + 999) / 1000)
// byte-load window in us, spacing kept well inside it (longest, round down)
`define PEW_LOAD_WIN_US 100
`define PEW_LOAD_WIN_CYC (`PEW_LOAD_WIN_US * `PEW_CLK_MHZ)
// wait beyond the window so the device surely closes the page
`define PEW_CLOSE_CYC (`PEW_LOAD_WIN_CYC + `PEW_LOAD_WIN_CYC / 4)
// programming time in us; the timeout parameter defaults to four times it
`define PEW_PROG_US 5000
`define PEW_PROG_CYC (`PEW_PROG_US * `PEW_CLK_MHZ)
`define PEW_TMO_CYC (`PEW_PROG_CYC * 4)

`endif

//--- hdl/pew_host.v
/*
  host-side controller driving a byte-wide eeprom through its pins:
  reads, byte or page writes, then end-of-write detection by polling.
  assumes a device on the pins with open-drain free three-state data
  lines; the testbench resolves data_lines from the enable.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pew_consts.vh"

// How it works
// [R01] select held low during every access, high while idle for standby
// [R02] thirteen-bit word address drives one byte location per access
// [R03] read opens with select and output enable low, closes raising both
// [R04] host releases data lines whenever it reads; device floats otherwise
// [R05] write asserts select and write enable low with output enable high
// [R06] address set up before the later falling strobe edge
// [R07] data held stable through the earlier rising strobe edge
// [R08] after loading, host waits for self-timed programming to finish
// [R09] page holds one to sixty-four bytes before programming starts
// [R10] further bytes use the same strobe protocol as the first
// [R11] page bits six to twelve forced equal to first byte's page
// [R12] each further write-enable fall issued well within the load window
// [R13] after the last byte host idles past the window to close the page
// [R14] host keeps loading as long as bytes arrive, up to sixty-four per page
// [R15] polling read of last byte shows inverted bit seven while busy
// [R16] done when bit seven of last byte matches written value
// [R17] host repeatedly reads last written address to test bit seven
// [R18] protected illegal write gives no polling; timeout flags it
// [R19] toggle mode compares bit six of successive reads
// [R20] toggle stops between reads means programming done
// [R21] protection unlock sequence is the user's writes, not issued here
// [R22] write-enable low pulses far exceed twenty nanoseconds
// [R23] no new write issued until programming is seen complete
// [R24] programming timeout is a parameter, default from typical time
module pew_host #(
  parameter LOAD_GAP_CYC = `PEW_LOAD_WIN_CYC / 2,
  parameter CLOSE_CYC = `PEW_CLOSE_CYC,
  parameter TMO_CYC = `PEW_TMO_CYC
) (
  input wire clk,
  input wire nrst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire cmd_last,
  input wire cmd_toggle_poll,
  input wire [`PEW_ADDR_W-1:0] cmd_addr,
  input wire [`PEW_DATA_W-1:0] cmd_data,
  output reg cmd_ready_r,
  output reg rd_valid_r,
  output reg [`PEW_DATA_W-1:0] rd_data_r,
  output reg busy_r,
  output reg done_r,
  output reg timeout_r,
  output reg [`PEW_ADDR_W-1:0] word_address_r,
  output reg select_n_r,
  output reg out_en_n_r,
  output reg wr_en_n_r,
  input wire [`PEW_DATA_W-1:0] data_lines_in,
  output reg [`PEW_DATA_W-1:0] data_lines_out_r,
  output reg data_lines_oe_r
);

  //--------------------------------------------------------------
  // states and counters
  //--------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WSET = 3'd1;
  localparam [2:0] ST_WLOW = 3'd2;
  localparam [2:0] ST_WHOLD = 3'd3;
  localparam [2:0] ST_LOAD = 3'd4;
  localparam [2:0] ST_RLOW = 3'd5;
  localparam [2:0] ST_RGAP = 3'd6;
  localparam [2:0] ST_POLL = 3'd7;
  localparam [31:0] STROBE_C = `PEW_STROBE_CYC;
  localparam [31:0] READ_C = `PEW_READ_CYC;

  reg [2:0] state_r;
  reg [31:0] cnt_r;
  reg [31:0] prog_r;
  reg [6:0] page_cnt_r;
  reg [`PEW_ADDR_W-`PEW_PAGE_LSB-1:0] page_r;
  reg [`PEW_ADDR_W-1:0] last_addr_r;
  reg [`PEW_DATA_W-1:0] last_data_r;
  reg [`PEW_DATA_W-1:0] prev_rd_r;
  reg have_prev_r;
  reg polling_r;
  reg toggle_r;
  reg last_byte_r;
  reg [`PEW_DATA_W-1:0] din_s1_r;
  reg [`PEW_DATA_W-1:0] din_s2_r;

  //--------------------------------------------------------------
  // data line input synchroniser
  //--------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else begin
      din_s1_r <= data_lines_in;
      din_s2_r <= din_s1_r;
    end
  end

  //--------------------------------------------------------------
  // main sequencer
  //--------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      cnt_r <= 32'h0;
      prog_r <= 32'h0;
      page_cnt_r <= 7'h00;
      page_r <= 7'h00;
      last_addr_r <= 13'h0000;
      last_data_r <= 8'h00;
      prev_rd_r <= 8'h00;
      have_prev_r <= 1'b0;
      polling_r <= 1'b0;
      toggle_r <= 1'b0;
      last_byte_r <= 1'b0;
      cmd_ready_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      timeout_r <= 1'b0;
      word_address_r <= 13'h0000;
      select_n_r <= 1'b1;
      out_en_n_r <= 1'b1;
      wr_en_n_r <= 1'b1;
      data_lines_out_r <= 8'h00;
      data_lines_oe_r <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= cnt_r + 32'h1;
      if (busy_r) begin
        prog_r <= prog_r + 32'h1;
      end
      case (state_r)
        ST_IDLE: begin
          select_n_r <= 1'b1; // R01
          cmd_ready_r <= !busy_r; // R23
          if (cmd_valid && cmd_ready_r) begin
            cmd_ready_r <= 1'b0;
            cnt_r <= 32'h0;
            word_address_r <= cmd_addr; // R02
            if (cmd_write) begin
              page_r <= cmd_addr[`PEW_ADDR_W-1:`PEW_PAGE_LSB];
              page_cnt_r <= 7'h01;
              last_byte_r <= cmd_last;
              last_addr_r <= cmd_addr;
              last_data_r <= cmd_data;
              toggle_r <= cmd_toggle_poll;
              data_lines_out_r <= cmd_data;
              data_lines_oe_r <= 1'b1;
              out_en_n_r <= 1'b1; // R05
              state_r <= ST_WSET;
            end else begin
              polling_r <= 1'b0;
              state_r <= ST_RGAP;
            end
          end
        end
        ST_WSET: begin
          // address and data settle before strobes fall
          select_n_r <= 1'b0; // R01
          if (cnt_r >= STROBE_C) begin
            wr_en_n_r <= 1'b0; // R06
            cnt_r <= 32'h0;
            state_r <= ST_WLOW;
          end
        end
        ST_WLOW: begin
          if (cnt_r >= STROBE_C) begin
            wr_en_n_r <= 1'b1; // R22
            cnt_r <= 32'h0;
            state_r <= ST_WHOLD;
          end
        end
        ST_WHOLD: begin
          if (cnt_r >= STROBE_C) begin
            select_n_r <= 1'b1;
            data_lines_oe_r <= 1'b0; // R07
            cnt_r <= 32'h0;
            if (last_byte_r || page_cnt_r == 7'd`PEW_PAGE_BYTES) begin // R09
              state_r <= ST_LOAD;
            end else begin
              cmd_ready_r <= 1'b1; // R10
              state_r <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (cmd_ready_r && cmd_valid && cmd_write) begin
            // R14
            cmd_ready_r <= 1'b0;
            cnt_r <= 32'h0;
            word_address_r <= {page_r,
              cmd_addr[`PEW_PAGE_LSB-1:0]}; // R11
            last_addr_r <= {page_r, cmd_addr[`PEW_PAGE_LSB-1:0]};
            last_data_r <= cmd_data;
            last_byte_r <= cmd_last;
            page_cnt_r <= page_cnt_r + 7'h01;
            data_lines_out_r <= cmd_data;
            data_lines_oe_r <= 1'b1;
            state_r <= ST_WSET;
          end else if (cmd_ready_r && cnt_r >= LOAD_GAP_CYC) begin
            cmd_ready_r <= 1'b0; // R12
          end else if (!cmd_ready_r && cnt_r >= CLOSE_CYC) begin
            busy_r <= 1'b1; // R13
            prog_r <= 32'h0;
            polling_r <= 1'b1;
            have_prev_r <= 1'b0;
            timeout_r <= 1'b0;
            word_address_r <= last_addr_r; // R17
            cnt_r <= 32'h0;
            state_r <= ST_RGAP;
          end
        end
        ST_RGAP: begin
          select_n_r <= 1'b1;
          out_en_n_r <= 1'b1;
          if (cnt_r >= STROBE_C) begin
            select_n_r <= 1'b0; // R03
            out_en_n_r <= 1'b0;
            data_lines_oe_r <= 1'b0; // R04
            cnt_r <= 32'h0;
            state_r <= ST_RLOW;
          end
        end
        ST_RLOW: begin
          if (cnt_r >= READ_C) begin
            select_n_r <= 1'b1; // R03
            out_en_n_r <= 1'b1;
            prev_rd_r <= din_s2_r;
            cnt_r <= 32'h0;
            state_r <= polling_r ? ST_POLL : ST_IDLE;
            if (!polling_r) begin
              rd_data_r <= din_s2_r;
              rd_valid_r <= 1'b1;
            end
          end
        end
        ST_POLL: begin
          have_prev_r <= 1'b1;
          if (toggle_r ? (have_prev_r && prev_rd_r[6] ==
              rd_data_r[6]) : // R19 R20
              (prev_rd_r[7] == last_data_r[7])) begin // R15 R16
            busy_r <= 1'b0;
            done_r <= 1'b1;
            polling_r <= 1'b0;
            state_r <= ST_IDLE;
          end else if (prog_r >= TMO_CYC) begin
            busy_r <= 1'b0; // R18 R24
            timeout_r <= 1'b1;
            polling_r <= 1'b0;
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_RGAP; // R08
          end
          rd_data_r <= prev_rd_r;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- bench/pew_host_properties.sv
/*
  port checker for pew_host: strobe order, bus ownership, holds.
  assumes binding to every pew_host instance, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pew_host_chk (
  input wire clk,
  input wire nrst,
  input wire cmd_ready_r,
  input wire busy_r,
  input wire done_r,
  input wire select_n_r,
  input wire out_en_n_r,
  input wire wr_en_n_r,
  input wire data_lines_oe_r,
  input wire [12:0] word_address_r,
  input wire [7:0] data_lines_out_r
);
  // ----
  // properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence rd_open;
    !select_n_r && !out_en_n_r;
  endsequence
  sequence we_held;
    !wr_en_n_r[*5];
  endsequence
  AST_STANDBY: assert property (
    cmd_ready_r |-> select_n_r && wr_en_n_r && out_en_n_r)
    else $error("strobe low while ready");
  AST_ADDR_HOLD: assert property (
    !select_n_r && !$past(select_n_r) |-> $stable(word_address_r))
    else $error("address moved while selected");
  AST_READ_OPEN: assert property (
    $fell(out_en_n_r) |-> rd_open[*8])
    else $error("read strobes closed early");
  AST_NO_CONTEND: assert property (
    !out_en_n_r |-> !data_lines_oe_r)
    else $error("host drives during read");
  AST_WRITE_COMBO: assert property (
    !wr_en_n_r |-> out_en_n_r && !select_n_r && data_lines_oe_r)
    else $error("bad write strobe combination");
  AST_DATA_HOLD: assert property (
    $rose(wr_en_n_r) |-> $stable(data_lines_out_r) && data_lines_oe_r)
    else $error("data not held at write end");
  AST_WE_WIDTH: assert property (
    $fell(wr_en_n_r) |-> we_held)
    else $error("write pulse too short");
  AST_DONE_BUSY: assert property (
    done_r |-> $past(busy_r))
    else $error("done without busy");
  AST_BUSY_NO_WRITE: assert property (
    busy_r |-> wr_en_n_r)
    else $error("write during programming");
endmodule
bind pew_host pew_host_chk pew_host_chk_inst (.clk, .nrst, .cmd_ready_r,
  .busy_r, .done_r, .select_n_r, .out_en_n_r, .wr_en_n_r,
  .data_lines_oe_r, .word_address_r, .data_lines_out_r);
`default_nettype wire

//--- bench/pew_dev.sv
/*
  eeprom device model: page load window, timed programming, status bits.
  assumes host strobes registered on clk; times are clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module pew_dev #(parameter WIN = 30, parameter PROG = 200) (
  input wire clk,
  input wire prot,
  input wire sel_n,
  input wire oe_n,
  input wire we_n,
  input wire [12:0] adr,
  input wire [7:0] din,
  output logic [7:0] dout
);
  logic [7:0] mem [0:8191];
  logic [7:0] last_d = 0, held = 0, rv;
  logic wq = 1, rq = 1, tog = 0;
  int win_c = 0, prog_c = 0;
  wire drv = !sel_n && !oe_n;
  // status bits while programming
  always_comb begin
    rv = mem[adr];
    if (prog_c > 0) rv = {~last_d[7], tog, mem[adr][5:0]};
  end
  assign dout = drv ? rv : ~held;
  always @(posedge clk) begin
    wq <= we_n | sel_n;
    rq <= oe_n | sel_n;
    if (drv) held <= rv;
    if (prog_c > 0) prog_c <= prog_c - 1;
    if (win_c > 0) win_c <= win_c - 1;
    if (win_c == 1) prog_c <= PROG;
    if (wq && !(we_n | sel_n) && oe_n && !prot && prog_c == 0)
      win_c <= WIN;
    if (!wq && (we_n | sel_n) && win_c > 0) begin
      mem[adr] <= din;
      last_d <= din;
    end
    if (rq && drv && prog_c > 0) tog <= ~tog;
  end
  initial for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
endmodule
`default_nettype wire

//--- bench/test_pew_host.sv
/*
  self-checking bench for pew_host: byte, page and protected writes.
  assumes pew_dev model on the pins and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module test_pew_host;
  // ----
  // clock, wiring, instances
  // ----
  logic clk = 0, nrst = 0, v = 0, w = 0, l = 0, tg = 0, prot = 0;
  logic [12:0] a = 0;
  logic [7:0] d = 0;
  wire rdy, rdv, bsy, dn, tmo, sn, oen, wen, hoe;
  wire [12:0] wa;
  wire [7:0] rdd, hout, dout;
  wire [7:0] bus = hoe ? hout : dout;
  int fail_count = 0, tests_run = 0, cyc = 0;
  logic [7:0] shadow [0:8191];
  always #10 clk = ~clk;
  pew_host #(.LOAD_GAP_CYC(20), .CLOSE_CYC(40), .TMO_CYC(2000)) pew_host_inst (
    .clk(clk), .nrst(nrst), .cmd_valid(v), .cmd_write(w), .cmd_last(l),
    .cmd_toggle_poll(tg), .cmd_addr(a), .cmd_data(d), .cmd_ready_r(rdy),
    .rd_valid_r(rdv), .rd_data_r(rdd), .busy_r(bsy), .done_r(dn),
    .timeout_r(tmo), .word_address_r(wa), .select_n_r(sn),
    .out_en_n_r(oen), .wr_en_n_r(wen), .data_lines_in(bus),
    .data_lines_out_r(hout), .data_lines_oe_r(hoe));
  pew_dev pew_dev_inst (.clk(clk), .prot(prot), .sel_n(sn), .oe_n(oen),
    .we_n(wen), .adr(wa), .din(bus), .dout(dout));
  // ----
  // tasks and expectations
  // ----
  function automatic logic [12:0] page_adr(input logic [12:0] f, n);
    return {f[12:6], n[5:0]};
  endfunction
  task automatic send(input logic wr, ls, tp, input logic [12:0] ad,
                      input logic [7:0] da);
    v <= 1;
    w <= wr;
    l <= ls;
    tg <= tp;
    a <= ad;
    d <= da;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  task automatic wait_done();
    v <= 0;
    do @(posedge clk); while (dn !== 1'b1 && tmo !== 1'b1);
  endtask
  task automatic rd(input logic [12:0] ad, input logic [7:0] ex);
    send(0, 0, 0, ad, 8'h00);
    v <= 0;
    do @(posedge clk); while (rdv !== 1'b1);
    `CHK(rdd, ex)
  endtask
  task automatic results();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  // ----
  // tests
  // ----
  initial begin
    logic [12:0] ad, pg;
    logic [7:0] da;
    void'($urandom(32'h97d3));
    repeat (10) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      ad = $urandom;
      da = (i < 2) ? {i[0], 7'h00} : 8'($urandom);
      send(1, 1, i[0], ad, da);
      wait_done();
      `CHK(tmo, 1'b0)
      shadow[ad] = da;
      rd(ad, da);
    end
    $display("test byte writes ended");
    pg = $urandom;
    pg[5:0] = 6'h00;
    for (int j = 0; j < 64; j++) begin
      ad = $urandom;
      ad[5:0] = j[5:0];
      if (j == 0) ad = pg;
      da = $urandom;
      send(1, j == 63, 0, ad, da);
      shadow[page_adr(pg, ad)] = da;
    end
    wait_done();
    `CHK(tmo, 1'b0)
    for (int j = 0; j < 64; j++) begin
      ad = page_adr(pg, j[12:0]);
      rd(ad, shadow[ad]);
    end
    $display("test page write ended");
    prot <= 1;
    send(1, 1, 0, ad, ~shadow[ad]);
    wait_done();
    `CHK(tmo, 1'b1)
    prot <= 0;
    rd(ad, shadow[ad]);
    $display("test protected write ended");
    results();
  end
endmodule
`default_nettype wire
